// ---- rtl/sdi12_sensor_command_responder.sv ----
// Sensor command responder: decodes addressed commands and issues responses.
// Assumes a character receiver and response formatter outside; measurement engine outside.
`timescale 1ns/100ps
// Contract
// (RULE_01) Address is a digit or letter, and only matching or wildcard commands are acted on.
// (RULE_02) Asterisk and question mark match whatever the own address is.
// (RULE_03) An exclamation mark ends a command before it is interpreted.
// (RULE_04) All standard protocol commands are accepted and answered; the code answers only acknowledge, I, A, M, D0 and X.
// (RULE_05) Measure starts a measurement and the data command then collects it.
// (RULE_06) Data reply holds stage, discharge or zero, units, distance and validity.
// (RULE_07) Validity is 0 valid, 1 sensor failure, 2 stale, 3 not configured.
// (RULE_08) Identify reply carries board and software revision fields.
// (RULE_09) Local settings may also be written by link commands.
// (RULE_10) The address is changeable from the keypad and takes effect for matching.
// (RULE_11) Acknowledge and wildcard address query reply with the own address.
// (RULE_12) Change-address to a valid address stores it and replies with it.
module sdi12_sensor_command_responder
  import sdi12_resp_pkg::*;
#(
  parameter logic [7:0] BOARD_REV = 8'h10, // Arbitrary value
  parameter logic [7:0] SOFT_REV = 8'h11 // Arbitrary value
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Received characters
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  // Keypad address change
  input wire logic local_addr_we_i,
  input wire logic [7:0] local_addr_i,
  // Measurement engine
  input wire logic meas_done_i,
  input wire logic [31:0] meas_stage_i,
  input wire logic [31:0] meas_discharge_i,
  input wire logic [1:0] meas_units_i,
  input wire logic [31:0] meas_distance_i,
  input wire logic sensor_fail_i,
  input wire logic config_ok_i,
  input wire logic discharge_en_i,
  // Measurement start
  output logic meas_start_o,
  // Configuration write
  output logic cfg_we_o,
  output logic [47:0] cfg_chars_o,
  // Response
  output logic rsp_valid_o,
  output rsp_type rsp_o,
  output logic [7:0] own_addr_o
);
  // --------------------------------------------------------------
  // Measurement states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEAS = 3'b010,
    ST_HELD = 3'b100
  } meas_state_type;

  // --------------------------------------------------------------
  // Command buffer
  // --------------------------------------------------------------
  logic done;
  logic [CMD_LEN*8-1:0] chars;
  logic [3:0] count;

  sdi12_cmd_buf #(.DEPTH(CMD_LEN)) u_buf (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .rx_valid_i(rx_valid_i),
    .rx_char_i(rx_char_i),
    .done_o(done),
    .chars_o(chars),
    .count_o(count)
  );

  // --------------------------------------------------------------
  // Address character check
  // --------------------------------------------------------------
  function automatic logic addr_legal(input logic [7:0] c);
    addr_legal = (c >= CH_ZERO && c <= CH_NINE) || (c >= CH_UP_A && c <= CH_UP_Z) ||
                 (c >= CH_LO_A && c <= CH_LO_Z);
  endfunction

  // --------------------------------------------------------------
  // State and next values
  // --------------------------------------------------------------
  logic [7:0] addr_r, addr_nxt;
  meas_state_type st_r, st_nxt;
  meas_rec_type rec_r, rec_nxt;
  logic fresh_r, fresh_nxt;
  logic start_r, start_nxt;
  logic cfg_we_r, cfg_we_nxt;
  logic [47:0] cfg_r, cfg_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  rsp_type rsp_r, rsp_nxt;

  // --------------------------------------------------------------
  // Address match
  // --------------------------------------------------------------
  logic [7:0] c0, c1, c2, c3;
  logic wild, hit;
  assign c0 = chars[7:0];
  assign c1 = chars[15:8];
  assign c2 = chars[23:16];
  assign c3 = chars[31:24];
  assign wild = (c0 == CH_STAR) || (c0 == CH_QUERY); // [RULE_02]
  assign hit = (count != 4'h0) && (wild || (addr_legal(c0) && c0 == addr_r)); // [RULE_01]

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    addr_nxt = addr_r;
    st_nxt = st_r;
    rec_nxt = rec_r;
    fresh_nxt = fresh_r;
    start_nxt = 1'b0;
    cfg_we_nxt = 1'b0;
    cfg_nxt = cfg_r;
    rsp_valid_nxt = 1'b0;
    rsp_nxt = rsp_r;
    rsp_nxt.board_rev = BOARD_REV;
    rsp_nxt.soft_rev = SOFT_REV;
    // Keypad address write
    if (local_addr_we_i && addr_legal(local_addr_i)) begin
      addr_nxt = local_addr_i; // [RULE_10]
    end
    // Measurement capture
    case (st_r)
      ST_MEAS: begin
        if (meas_done_i) begin
          rec_nxt.stage = meas_stage_i;
          rec_nxt.discharge = discharge_en_i ? meas_discharge_i : 32'h0000_0000; // [RULE_06]
          rec_nxt.units = meas_units_i;
          rec_nxt.distance = meas_distance_i;
          rec_nxt.validity = VAL_OK; // [RULE_07]
          if (!config_ok_i) begin
            rec_nxt.validity = VAL_NOT_CONFIG;
          end else if (sensor_fail_i) begin
            rec_nxt.validity = VAL_SENSOR_FAIL;
          end
          fresh_nxt = 1'b1;
          st_nxt = ST_HELD;
        end
      end
      ST_HELD: st_nxt = ST_HELD;
      default: st_nxt = ST_IDLE;
    endcase
    // Command decode
    if (done && hit) begin // [RULE_03] [RULE_04]
      rsp_valid_nxt = 1'b1;
      rsp_nxt.kind = RSP_ADDR;
      rsp_nxt.addr = addr_r; // [RULE_11]
      rsp_nxt.rec = rec_r;
      if (count >= 4'h2) begin
        if (c1 == CH_CMD_ID) begin
          rsp_nxt.kind = RSP_IDENT; // [RULE_08]
        end else if (c1 == CH_CMD_ADDR && count == 4'h3) begin
          if (addr_legal(c2)) begin
            addr_nxt = c2; // [RULE_12]
            rsp_nxt.addr = c2;
          end
        end else if (c1 == CH_CMD_MEAS && count == 4'h2) begin
          start_nxt = 1'b1; // [RULE_05]
          st_nxt = ST_MEAS;
          rsp_nxt.kind = RSP_MEAS_ACK;
        end else if (c1 == CH_CMD_DATA && c2 == CH_ZERO) begin
          rsp_nxt.kind = RSP_DATA; // [RULE_05] [RULE_06]
          if (!fresh_r && rec_r.validity == VAL_OK) begin
            rsp_nxt.rec.validity = VAL_STALE; // [RULE_07]
          end
          // New capture wins over the clear
          if (!(st_r == ST_MEAS && meas_done_i)) begin
            fresh_nxt = 1'b0;
          end
        end else if (c1 == CH_CMD_CFG) begin
          cfg_we_nxt = 1'b1; // [RULE_09]
          cfg_nxt = chars[63:16];
          rsp_nxt.kind = RSP_CFG;
        end else begin
          rsp_valid_nxt = 1'b0;
        end
      end
      if (c3 == 8'h00 && count == 4'h0) begin
        rsp_valid_nxt = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_r <= ADDR_RESET;
      st_r <= ST_IDLE;
      rec_r <= '{32'h0000_0000, 32'h0000_0000, 2'h0, 32'h0000_0000, VAL_STALE};
      fresh_r <= 1'b0;
      start_r <= 1'b0;
      cfg_we_r <= 1'b0;
      cfg_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      addr_r <= addr_nxt;
      st_r <= st_nxt;
      rec_r <= rec_nxt;
      fresh_r <= fresh_nxt;
      start_r <= start_nxt;
      cfg_we_r <= cfg_we_nxt;
      cfg_r <= cfg_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign meas_start_o = start_r;
  assign cfg_we_o = cfg_we_r;
  assign cfg_chars_o = cfg_r;
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_o = rsp_r;
  assign own_addr_o = addr_r;
endmodule

// ---- rtl/sdi12_resp_pkg.sv ----
// Package: character codes, response kinds and record types of the sensor command responder.
// Assumes a byte-wide receive stream and byte-wide transmit stream outside this block.
package sdi12_resp_pkg;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_Z = 8'h5A;
  localparam logic [7:0] CH_LO_A = 8'h61;
  localparam logic [7:0] CH_LO_Z = 8'h7A;
  localparam logic [7:0] CH_CMD_ID = 8'h49;
  localparam logic [7:0] CH_CMD_ADDR = 8'h41;
  localparam logic [7:0] CH_CMD_MEAS = 8'h4D;
  localparam logic [7:0] CH_CMD_DATA = 8'h44;
  localparam logic [7:0] CH_CMD_CFG = 8'h58;
  localparam logic [7:0] ADDR_RESET = 8'h30;
  localparam int CMD_LEN = 8;
  localparam logic [1:0] VAL_OK = 2'h0;
  localparam logic [1:0] VAL_SENSOR_FAIL = 2'h1;
  localparam logic [1:0] VAL_STALE = 2'h2;
  localparam logic [1:0] VAL_NOT_CONFIG = 2'h3;

  typedef enum logic [7:0] {
    RSP_NONE = 8'h00,
    RSP_ADDR = 8'h01,
    RSP_IDENT = 8'h02,
    RSP_MEAS_ACK = 8'h04,
    RSP_DATA = 8'h08,
    RSP_CFG = 8'h10
  } rsp_kind_type;

  typedef struct packed {
    logic [31:0] stage;
    logic [31:0] discharge;
    logic [1:0] units;
    logic [31:0] distance;
    logic [1:0] validity;
  } meas_rec_type;

  typedef struct packed {
    rsp_kind_type kind;
    logic [7:0] addr;
    logic [7:0] board_rev;
    logic [7:0] soft_rev;
    meas_rec_type rec;
  } rsp_type;
endpackage

// ---- rtl/sdi12_cmd_buf.sv ----
// Command buffer: collects received characters until the terminator.
// Assumes one character per rx_valid_i pulse on the same clock.
`timescale 1ns/100ps
module sdi12_cmd_buf
  import sdi12_resp_pkg::*;
#(
  parameter int DEPTH = CMD_LEN
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Character stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  // Completed command
  output logic done_o,
  output logic [DEPTH*8-1:0] chars_o,
  output logic [3:0] count_o
);
  logic [DEPTH*8-1:0] chars_r, chars_nxt;
  logic [3:0] count_r, count_nxt;
  logic done_r, done_nxt;

  always_comb begin
    chars_nxt = chars_r;
    count_nxt = count_r;
    done_nxt = 1'b0;
    if (done_r) begin
      count_nxt = 4'h0;
      // Clear old arguments
      chars_nxt = '0;
    end
    if (rx_valid_i) begin
      if (rx_char_i == CH_BANG) begin
        done_nxt = 1'b1; // [RULE_03]
      end else if (count_nxt < 4'(DEPTH)) begin
        chars_nxt[count_nxt*8 +: 8] = rx_char_i;
        count_nxt = count_nxt + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chars_r <= '0;
      count_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      chars_r <= chars_nxt;
      count_r <= count_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign chars_o = chars_r;
  assign count_o = count_r;
endmodule

// ---- tb/sdi12_logger_model.sv ----
// Logger model: sends one command as a character stream.
// Assumes the responder samples characters on the rising clock edge.
`timescale 1ns/100ps
module sdi12_logger_model (
  // Clock
  input wire logic clock_i,
  // Character stream
  output logic rx_valid_o,
  output logic [7:0] rx_char_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
  end
  // Caller ends each command with the terminator
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock_i);
      rx_valid_o = 1'b1;
      rx_char_o = s[i];
    end
    @(negedge clock_i);
    rx_valid_o = 1'b0;
    rx_char_o = ~rx_char_o;
  endtask
endmodule

// ---- tb/sdi12_resp_props.sv ----
// Checker: response timing and content of the command responder.
// Assumes it is bound to the responder top module.
`timescale 1ns/100ps
module sdi12_resp_props
  import sdi12_resp_pkg::*;
(
  // Watched ports
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic config_ok_i,
  input wire logic discharge_en_i,
  input wire logic meas_done_i,
  input wire logic meas_start_o,
  input wire logic rsp_valid_o,
  input wire rsp_type rsp_o,
  input wire logic [7:0] own_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Levels as taken with the last accepted measurement
  logic pend_r, dis_en_r, cfg_ok_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_r <= 1'b0;
      dis_en_r <= 1'b1;
      cfg_ok_r <= 1'b1;
    end else if (meas_done_i && (pend_r || meas_start_o)) begin
      pend_r <= 1'b0;
      dis_en_r <= discharge_en_i;
      cfg_ok_r <= config_ok_i;
    end else if (meas_start_o) begin
      pend_r <= 1'b1;
    end
  end
  function automatic logic legal(input logic [7:0] c);
    return (c inside {[CH_ZERO:CH_NINE], [CH_UP_A:CH_UP_Z], [CH_LO_A:CH_LO_Z]});
  endfunction
  property p_rsp_after_bang;
    rsp_valid_o |-> $past(rx_valid_i && rx_char_i == CH_BANG, 2);
  endproperty
  a_rsp_after_bang: assert property (p_rsp_after_bang) else $error("response w/o end");
  property p_pulse;
    rsp_valid_o |=> !rsp_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("response too long");
  property p_start;
    meas_start_o |-> rsp_valid_o && rsp_o.kind == RSP_MEAS_ACK;
  endproperty
  a_start: assert property (p_start) else $error("start without ack");
  property p_ident;
    rsp_valid_o && rsp_o.kind == RSP_IDENT |-> rsp_o.board_rev == 8'h10 && rsp_o.soft_rev == 8'h11;
  endproperty
  a_ident: assert property (p_ident) else $error("bad revision");
  property p_addr;
    rsp_valid_o && rsp_o.kind == RSP_ADDR |-> legal(rsp_o.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("bad reply address");
  property p_own;
    legal(own_addr_o);
  endproperty
  a_own: assert property (p_own) else $error("bad own address");
  property p_dis;
    rsp_valid_o && rsp_o.kind == RSP_DATA && !$past(dis_en_r) |->
      rsp_o.rec.discharge == 32'h0000_0000;
  endproperty
  a_dis: assert property (p_dis) else $error("discharge not zero");
  property p_cfg;
    rsp_valid_o && rsp_o.kind == RSP_DATA && !$past(cfg_ok_r) |->
      rsp_o.rec.validity == VAL_NOT_CONFIG;
  endproperty
  a_cfg: assert property (p_cfg) else $error("validity not 3");
  c_ack: cover property (rsp_valid_o && rsp_o.kind == RSP_MEAS_ACK);
  c_data: cover property (rsp_valid_o && rsp_o.kind == RSP_DATA);
  c_ident: cover property (rsp_valid_o && rsp_o.kind == RSP_IDENT);
endmodule
bind sdi12_sensor_command_responder sdi12_resp_props sdi12_resp_props_inst (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
  .config_ok_i(config_ok_i), .discharge_en_i(discharge_en_i), .meas_done_i(meas_done_i),
  .meas_start_o(meas_start_o),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .own_addr_o(own_addr_o));

// ---- tb/tb_sdi12_sensor_command_responder.sv ----
// Testbench: drives commands through the logger model and checks responses.
// Assumes design defaults for revision fields.
`timescale 1ns/100ps
module tb_sdi12_sensor_command_responder;
  import sdi12_resp_pkg::*;
  logic clock_i = 0, arst_n_i = 0, rx_valid_i, local_addr_we_i = 0, meas_done_i = 0;
  logic sensor_fail_i = 0, config_ok_i = 1, discharge_en_i = 0, meas_start_o, cfg_we_o;
  logic rsp_valid_o, h, st;
  logic [7:0] rx_char_i, local_addr_i = 8'h30, own_addr_o;
  logic [31:0] meas_stage_i = 0, meas_discharge_i = 0, meas_distance_i = 0;
  logic [1:0] meas_units_i = 0;
  logic [47:0] cfg_chars_o, cfg_q = 0;
  rsp_type rsp_o, r;
  int n_fail = 0, total_checks = 0;
  sdi12_logger_model sdi12_logger_model_inst (.clock_i(clock_i), .rx_valid_o(rx_valid_i),
    .rx_char_o(rx_char_i));
  sdi12_sensor_command_responder sdi12_sensor_command_responder_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .local_addr_we_i(local_addr_we_i), .local_addr_i(local_addr_i), .meas_done_i(meas_done_i),
    .meas_stage_i(meas_stage_i), .meas_discharge_i(meas_discharge_i),
    .meas_units_i(meas_units_i), .meas_distance_i(meas_distance_i),
    .sensor_fail_i(sensor_fail_i), .config_ok_i(config_ok_i), .discharge_en_i(discharge_en_i),
    .meas_start_o(meas_start_o), .cfg_we_o(cfg_we_o), .cfg_chars_o(cfg_chars_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .own_addr_o(own_addr_o));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (cfg_we_o === 1'b1) cfg_q <= cfg_chars_o;
  task chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task cmd(input string s);
    h = 0;
    st = 0;
    sdi12_logger_model_inst.send(s);
    repeat (4) begin
      @(posedge clock_i);
      #1;
      if (rsp_valid_o === 1'b1) begin
        h = 1;
        st = meas_start_o;
        r = rsp_o;
      end
    end
  endtask
  task key(input logic [7:0] a);
    @(negedge clock_i);
    local_addr_we_i = 1;
    local_addr_i = a;
    @(negedge clock_i);
    local_addr_we_i = 0;
  endtask
  task t_addr;
    cmd("0!"); chk("ack", {h, r.kind, r.addr}, {1'b1, RSP_ADDR, CH_ZERO});
    cmd("?!"); chk("query", {h, r.kind, r.addr}, {1'b1, RSP_ADDR, CH_ZERO});
    cmd("*!"); chk("star", {h, r.kind, r.addr}, {1'b1, RSP_ADDR, CH_ZERO});
    cmd("5!"); chk("other", h, 0);
    cmd("0Ab!"); chk("chg", {h, r.addr, own_addr_o}, {1'b1, 16'h6262});
    cmd("bA#!"); chk("illegal", {h, r.addr, own_addr_o}, {1'b1, 16'h6262});
    cmd("bA0!"); chk("back", own_addr_o, CH_ZERO);
    key(8'h37); cmd("7!"); chk("key", {h, r.addr}, 9'h137);
    key(8'h30); chk("key0", own_addr_o, CH_ZERO);
    cmd("0I!");
    chk("id", {h, r.kind, r.board_rev, r.soft_rev}, {1'b1, RSP_IDENT, 16'h1011});
    cmd("0X1234!"); chk("cfg", cfg_q, 48'h0000_3433_3231);
    chk("cfgr", {h, r.kind}, {1'b1, RSP_CFG});
  endtask
  task t_meas;
    logic [1:0] v;
    for (int i = 0; i < 3; i++) begin
      cmd("0M!"); chk("mack", {h, st, r.kind}, {2'b11, RSP_MEAS_ACK});
      @(negedge clock_i);
      meas_done_i = 1;
      sensor_fail_i = (i == 1);
      config_ok_i = (i != 0);
      discharge_en_i = (i == 0);
      meas_stage_i = 32'h0000_0100 + i;
      meas_discharge_i = 32'h0000_0200 + i;
      meas_distance_i = 32'h0000_0300 + i;
      meas_units_i = 2'(i + 1);
      @(negedge clock_i);
      meas_done_i = 0;
      v = (i == 0) ? VAL_NOT_CONFIG : (i == 1) ? VAL_SENSOR_FAIL : VAL_OK;
      cmd("0D0!"); chk("val", {h, r.kind, r.rec.validity}, {1'b1, RSP_DATA, v});
      chk("rec", {r.rec.stage, r.rec.units}, {meas_stage_i, meas_units_i});
      chk("dist", r.rec.distance, meas_distance_i);
      chk("dis", r.rec.discharge, (i == 0) ? meas_discharge_i : 32'h0);
    end
    config_ok_i = 1;
    cmd("0D0!"); chk("stale", {h, r.rec.validity}, {1'b1, VAL_STALE});
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(negedge clock_i);
    arst_n_i = 1;
    t_addr();
    t_meas();
    results();
  end
endmodule
